// *** design/dpwcs_pkg.sv ***
// Shared constants and types for the dual pot write command link
`default_nettype none
package dpwcs_pkg;
	// ==========================================================
	// Control byte layout
	localparam logic [3:0] CTRL_TYPE = 4'h5;
	localparam int CTRL_TYPE_MSB = 7;
	localparam int CTRL_TYPE_LSB = 4;
	localparam int CTRL_SEL_MSB = 3;
	localparam int CTRL_SEL_LSB = 1;
	localparam int CTRL_DIR_BIT = 0;
	localparam logic DIR_WRITE = 1'b0;
	// ==========================================================
	// Command bytes
	localparam logic [7:0] CMD_POT0 = 8'ha9;
	localparam logic [7:0] CMD_POT1 = 8'haa;
	localparam logic [7:0] CMD_BOTH = 8'haf;
	localparam logic [7:0] CMD_ZC_ON = 8'hbd;
	localparam logic [7:0] CMD_ZC_OFF = 8'hbe;
	// ==========================================================
	// Reset values
	localparam logic [7:0] WIPER_RST = 8'h00;
	localparam logic ZC_RST = 1'b1;
	// ==========================================================
	// Byte framing
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [1:0] DATA_IDX_MAX = 2'h3;
	// ==========================================================
	// Timing
	localparam int CLK_NS = 8;
	localparam int SPIKE_NS = 50;
	localparam logic [2:0] SPIKE_CYC = 3'((SPIKE_NS + CLK_NS - 1) / CLK_NS);
	localparam int QTR_NS = 720;
	localparam logic [6:0] QTR_CYC = 7'(QTR_NS / CLK_NS);
	// ==========================================================
	// State machines
	typedef enum logic [4:0] {
		DEV_IDLE = 5'h01,
		DEV_ADDR = 5'h02,
		DEV_CMD = 5'h04,
		DEV_DATA = 5'h08,
		DEV_SKIP = 5'h10
	} dpwcs_dev_state_t;
	typedef enum logic [3:0] {
		MST_IDLE = 4'h1,
		MST_START = 4'h2,
		MST_BIT = 4'h4,
		MST_STOP = 4'h8
	} dpwcs_mst_state_t;
endpackage
`default_nettype wire

// *** design/dpwcs_link_if.sv ***
// Two-wire link between the bus master and the pot device
`default_nettype none
interface dpwcs_link_if;
	logic sclMasterO;
	logic sclMasterOe;
	logic sdaMasterO;
	logic sdaMasterOe;
	logic sdaDevO;
	logic sdaDevOe;
	logic scl;
	logic sda;
	// ==========================================================
	// Open-drain wire levels, pulled up when nobody drives low
	assign scl = ~(sclMasterOe & ~sclMasterO);
	assign sda = ~((sdaMasterOe & ~sdaMasterO) | (sdaDevOe & ~sdaDevO));
	modport master (
		output sclMasterO,
		output sclMasterOe,
		output sdaMasterO,
		output sdaMasterOe,
		input scl,
		input sda
	);
	modport device (
		output sdaDevO,
		output sdaDevOe,
		input scl,
		input sda
	);
endinterface
`default_nettype wire

// *** design/dpwcs_master.sv ***
// Bus master end: sends control, command and wiper data bytes
`default_nettype none
module dpwcs_master
	import dpwcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	dpwcs_link_if.master link,
	input wire logic start,
	input wire logic [2:0] selectAddr,
	input wire logic [7:0] cmdByte,
	input wire logic [1:0] dataCount,
	input wire logic [7:0] data0,
	input wire logic [7:0] data1,
	output logic busy,
	output logic done,
	output logic ackError
);
	import dpwcs_pkg::*;

	// ==========================================================
	// Pin sampling
	logic sdaMeta;
	logic sdaSync;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sdaMeta <= 1'b1;
			sdaSync <= 1'b1;
		end else begin
			sdaMeta <= link.sda;
			sdaSync <= sdaMeta;
		end
	end

	// ==========================================================
	// Sequencer
	dpwcs_mst_state_t state, next_state;
	logic [6:0] tickCnt, next_tickCnt;
	logic [1:0] qtr, next_qtr;
	logic [3:0] bitIdx, next_bitIdx;
	logic [1:0] byteIdx, next_byteIdx;
	logic [1:0] lastByte, next_lastByte;
	logic [7:0] txBytes [4];
	logic [7:0] next_txBytes [4];
	logic sclOe, next_sclOe;
	logic sdaOe, next_sdaOe;
	logic next_busy;
	logic next_done;
	logic next_ackError;
	logic tick;

	always_comb begin
		next_state = state;
		next_tickCnt = tickCnt + 7'h01;
		next_qtr = qtr;
		next_bitIdx = bitIdx;
		next_byteIdx = byteIdx;
		next_lastByte = lastByte;
		next_txBytes = txBytes;
		next_sclOe = sclOe;
		next_sdaOe = sdaOe;
		next_busy = busy;
		next_done = 1'b0;
		next_ackError = ackError;
		tick = (tickCnt == QTR_CYC - 7'h01);
		if (tick) begin
			next_tickCnt = 7'h00;
		end
		case (state)
			MST_IDLE: begin
				next_tickCnt = 7'h00;
				next_sclOe = 1'b0;
				next_sdaOe = 1'b0;
				if (start) begin
					// Write control byte opens every transfer
					next_txBytes[0] = {CTRL_TYPE, selectAddr, DIR_WRITE};
					next_txBytes[1] = cmdByte;
					next_txBytes[2] = data0;
					next_txBytes[3] = data1;
					next_lastByte = 2'h1 + dataCount;
					next_busy = 1'b1;
					next_ackError = 1'b0;
					next_qtr = 2'h0;
					next_state = MST_START;
				end
			end
			MST_START: begin
				if (tick) begin
					next_qtr = qtr + 2'h1;
					if (qtr == 2'h0) begin
						next_sdaOe = 1'b1;
					end else begin
						next_sclOe = 1'b1;
						next_qtr = 2'h0;
						next_bitIdx = 4'h0;
						next_byteIdx = 2'h0;
						next_state = MST_BIT;
					end
				end
			end
			MST_BIT: begin
				if (tick) begin
					next_qtr = qtr + 2'h1;
					case (qtr)
						2'h0: begin
							// Data moves a quarter after SCL falls
							if (bitIdx == ACK_BIT) begin
								next_sdaOe = 1'b0;
							end else begin
								next_sdaOe = ~txBytes[byteIdx][~bitIdx[2:0]];
							end
						end
						2'h1: begin
							next_sclOe = 1'b0;
						end
						2'h3: begin
							next_sclOe = 1'b1;
							next_bitIdx = bitIdx + 4'h1;
							if (bitIdx == ACK_BIT) begin
								next_bitIdx = 4'h0;
								if (sdaSync) begin
									// No more bytes without an acknowledge
									next_ackError = 1'b1;
									next_state = MST_STOP;
								end else if (byteIdx == lastByte) begin
									next_state = MST_STOP;
								end else begin
									next_byteIdx = byteIdx + 2'h1;
								end
							end
						end
						default: begin
						end
					endcase
				end
			end
			MST_STOP: begin
				if (tick) begin
					next_qtr = qtr + 2'h1;
					case (qtr)
						2'h0: next_sdaOe = 1'b1;
						2'h1: next_sclOe = 1'b0;
						2'h2: next_sdaOe = 1'b0;
						default: begin
							next_busy = 1'b0;
							next_done = 1'b1;
							next_state = MST_IDLE;
						end
					endcase
				end
			end
			default: begin
				next_state = MST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= MST_IDLE;
			tickCnt <= 7'h00;
			qtr <= 2'h0;
			bitIdx <= 4'h0;
			byteIdx <= 2'h0;
			lastByte <= 2'h0;
			txBytes <= '{default: 8'h00};
			sclOe <= 1'b0;
			sdaOe <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			ackError <= 1'b0;
		end else begin
			state <= next_state;
			tickCnt <= next_tickCnt;
			qtr <= next_qtr;
			bitIdx <= next_bitIdx;
			byteIdx <= next_byteIdx;
			lastByte <= next_lastByte;
			txBytes <= next_txBytes;
			sclOe <= next_sclOe;
			sdaOe <= next_sdaOe;
			busy <= next_busy;
			done <= next_done;
			ackError <= next_ackError;
		end
	end

	// ==========================================================
	// Open-drain drivers only ever pull low
	assign link.sclMasterOe = sclOe;
	assign link.sdaMasterOe = sdaOe;
	assign link.sclMasterO = 1'b0;
	assign link.sdaMasterO = 1'b0;
endmodule
`default_nettype wire

// *** design/dpwcs_device.sv ***
// Pot device end: decodes write commands and holds wiper and mode state
`default_nettype none
module dpwcs_device
	import dpwcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	dpwcs_link_if.device link,
	input wire logic [2:0] addressSelectPins,
	output logic [7:0] wiper0,
	output logic [7:0] wiper1,
	output logic zeroCrossEn
);
	import dpwcs_pkg::*;

	function automatic logic isWiperCmd(input logic [7:0] cmd);
		isWiperCmd = (cmd == CMD_POT0) || (cmd == CMD_POT1) ||
			(cmd == CMD_BOTH);
	endfunction

	// ==========================================================
	// Pin sampling
	logic [4:0] pinMeta;
	logic [4:0] pinSync;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinMeta <= 5'h03;
			pinSync <= 5'h03;
		end else begin
			pinMeta <= {addressSelectPins, link.sda, link.scl};
			pinSync <= pinMeta;
		end
	end

	// ==========================================================
	// Spike filter: a level must persist past the spike width
	logic [1:0] lineF;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gFilt
			logic [2:0] cnt, next_cnt;
			logic filt, next_filt;
			always_comb begin
				next_cnt = 3'h0;
				next_filt = filt;
				if (pinSync[gi] != filt) begin
					next_cnt = cnt + 3'h1;
					if (cnt == SPIKE_CYC) begin
						next_filt = pinSync[gi];
						next_cnt = 3'h0;
					end
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					cnt <= 3'h0;
					filt <= 1'b1;
				end else begin
					cnt <= next_cnt;
					filt <= next_filt;
				end
			end
			assign lineF[gi] = filt;
		end
	endgenerate

	// ==========================================================
	// Bus conditions
	logic sclF;
	logic sdaF;
	logic sclPrev;
	logic sdaPrev;
	logic startCond;
	logic stopCond;
	logic sclRise;
	logic sclFall;
	assign sclF = lineF[0];
	assign sdaF = lineF[1];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclF;
			sdaPrev <= sdaF;
		end
	end
	assign startCond = sclF & sclPrev & sdaPrev & ~sdaF;
	assign stopCond = sclF & sclPrev & ~sdaPrev & sdaF;
	assign sclRise = sclF & ~sclPrev;
	assign sclFall = ~sclF & sclPrev;

	// ==========================================================
	// Byte engine and command decode
	dpwcs_dev_state_t state, next_state;
	logic [7:0] shiftReg, next_shift;
	logic [3:0] bitCnt, next_bitCnt;
	logic ackSlot, next_ackSlot;
	logic ackPend, next_ackPend;
	logic ackDrive, next_ackDrive;
	logic [7:0] cmdReg, next_cmd;
	logic [1:0] dataIdx, next_dataIdx;
	logic [7:0] next_wiper0;
	logic [7:0] next_wiper1;
	logic next_zc;
	logic [7:0] rxByte;
	logic counting;

	always_comb begin
		next_state = state;
		next_shift = shiftReg;
		next_bitCnt = bitCnt;
		next_ackSlot = ackSlot;
		next_ackPend = ackPend;
		next_ackDrive = ackDrive;
		next_cmd = cmdReg;
		next_dataIdx = dataIdx;
		next_wiper0 = wiper0;
		next_wiper1 = wiper1;
		next_zc = zeroCrossEn;
		rxByte = {shiftReg[6:0], sdaF};
		counting = ((state == DEV_ADDR) || (state == DEV_CMD) ||
			(state == DEV_DATA)) && (bitCnt != ACK_BIT);
		if (startCond) begin
			// Repeated START also lands here and restarts the frame
			next_state = DEV_ADDR;
			next_bitCnt = 4'h0;
			next_ackSlot = 1'b0;
			next_ackPend = 1'b0;
			next_ackDrive = 1'b0;
		end else if (stopCond) begin
			next_state = DEV_IDLE;
			next_bitCnt = 4'h0;
			next_ackSlot = 1'b0;
			next_ackPend = 1'b0;
			next_ackDrive = 1'b0;
		end else if (sclRise && counting) begin
			next_shift = rxByte;
			next_bitCnt = bitCnt + 4'h1;
			if (bitCnt == LAST_BIT) begin
				case (state)
					DEV_ADDR: begin
						next_state = DEV_SKIP;
						if (rxByte[CTRL_TYPE_MSB:CTRL_TYPE_LSB] == CTRL_TYPE &&
							rxByte[CTRL_SEL_MSB:CTRL_SEL_LSB] == pinSync[4:2] &&
							rxByte[CTRL_DIR_BIT] == DIR_WRITE) begin
							next_ackPend = 1'b1;
							next_state = DEV_CMD;
						end
					end
					DEV_CMD: begin
						next_ackPend = 1'b1;
						next_cmd = rxByte;
						next_dataIdx = 2'h0;
						if (rxByte == CMD_ZC_ON) begin
							next_zc = 1'b1;
						end else if (rxByte == CMD_ZC_OFF) begin
							next_zc = 1'b0;
						end
						// Mode and unknown commands take no data bytes
						next_state = isWiperCmd(rxByte) ? DEV_DATA : DEV_SKIP;
					end
					DEV_DATA: begin
						next_ackPend = 1'b1;
						if (dataIdx != DATA_IDX_MAX) begin
							next_dataIdx = dataIdx + 2'h1;
						end
						if (cmdReg == CMD_POT0 && dataIdx == 2'h0) begin
							next_wiper0 = rxByte;
						end else if (cmdReg == CMD_POT0 && dataIdx == 2'h1) begin
							next_wiper1 = rxByte;
						end else if (cmdReg == CMD_POT1 && dataIdx == 2'h0) begin
							next_wiper1 = rxByte;
						end else if (cmdReg == CMD_BOTH && dataIdx == 2'h0) begin
							next_wiper0 = rxByte;
							next_wiper1 = rxByte;
						end
					end
					default: begin
						next_state = DEV_SKIP;
					end
				endcase
			end
		end else if (sclFall && bitCnt == ACK_BIT) begin
			if (!ackSlot) begin
				// Pull SDA low through the whole ninth clock
				next_ackSlot = 1'b1;
				next_ackDrive = ackPend;
				next_ackPend = 1'b0;
			end else begin
				next_ackSlot = 1'b0;
				next_ackDrive = 1'b0;
				next_bitCnt = 4'h0;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= DEV_IDLE;
			shiftReg <= 8'h00;
			bitCnt <= 4'h0;
			ackSlot <= 1'b0;
			ackPend <= 1'b0;
			ackDrive <= 1'b0;
			cmdReg <= 8'h00;
			dataIdx <= 2'h0;
			wiper0 <= WIPER_RST;
			wiper1 <= WIPER_RST;
			zeroCrossEn <= ZC_RST;
		end else begin
			state <= next_state;
			shiftReg <= next_shift;
			bitCnt <= next_bitCnt;
			ackSlot <= next_ackSlot;
			ackPend <= next_ackPend;
			ackDrive <= next_ackDrive;
			cmdReg <= next_cmd;
			dataIdx <= next_dataIdx;
			wiper0 <= next_wiper0;
			wiper1 <= next_wiper1;
			zeroCrossEn <= next_zc;
		end
	end

	// ==========================================================
	// Acknowledge driver only ever pulls low
	assign link.sdaDevOe = ackDrive;
	assign link.sdaDevO = 1'b0;
endmodule
`default_nettype wire

// *** dv/dpwcs_link_props.sv ***
// Protocol checker for the shared two-wire link
`default_nettype none
module dpwcs_link_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic sclMasterO,
	input wire logic sclMasterOe,
	input wire logic sdaMasterO,
	input wire logic sdaMasterOe,
	input wire logic sdaDevO,
	input wire logic sdaDevOe,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Acknowledge length counter, too long for a plain delay
	logic [8:0] ackLen;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ackLen <= 9'h000;
		end else if (!sdaDevOe) begin
			ackLen <= 9'h000;
		end else if (ackLen != 9'h1ff) begin
			ackLen <= ackLen + 9'h001;
		end
	end
	// ==========================================================
	// Wire rules
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_openDrain;
		!sclMasterO && !sdaMasterO && !sdaDevO;
	endproperty
	a_openDrain: assert property (p_openDrain)
		else $error("open drain output value not low");
	property p_startHold;
		$rose(sdaMasterOe) && scl |-> ##89 !sclMasterOe ##1 sclMasterOe;
	endproperty
	a_startHold: assert property (p_startHold)
		else $error("start hold before first clock wrong");
	property p_stopIdle;
		$fell(sdaMasterOe) && scl |-> (!sclMasterOe && !sdaDevOe) [*8];
	endproperty
	a_stopIdle: assert property (p_stopIdle)
		else $error("bus not idle after stop");
	property p_devOeSclLow;
		$changed(sdaDevOe) |-> !scl;
	endproperty
	a_devOeSclLow: assert property (p_devOeSclLow)
		else $error("device data changed with clock high");
	property p_ackSpan;
		(sdaDevOe |-> ackLen < 9'h17c) and
			($fell(sdaDevOe) |-> ackLen > 9'h154);
	endproperty
	a_ackSpan: assert property (p_ackSpan)
		else $error("acknowledge length wrong");
	property p_ackLow;
		$rose(sdaDevOe) |-> ##[170:250] (scl && !sda);
	endproperty
	a_ackLow: assert property (p_ackLow)
		else $error("acknowledge not low in clock high");
	property p_sclLow;
		$rose(sclMasterOe) |-> ##179 sclMasterOe ##1 !sclMasterOe;
	endproperty
	a_sclLow: assert property (p_sclLow)
		else $error("clock low period wrong");
	property p_highHold;
		$fell(sclMasterOe) |-> $stable(sdaMasterOe) [*8];
	endproperty
	a_highHold: assert property (p_highHold)
		else $error("master data moved at clock rise");
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Testbench joining master and device ends over the link
`default_nettype none
module testbench
	import dpwcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Signals and ends
	localparam int BQ = 24;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [2:0] selectAddr = 3'h5;
	logic [7:0] cmdByte = 8'h00;
	logic [1:0] dataCount = 2'h0;
	logic [7:0] data0 = 8'h00;
	logic [7:0] data1 = 8'h00;
	logic busy, done, ackError, zeroCrossEn, zc2;
	logic [7:0] wiper0, wiper1, w2a, w2b;
	logic [9:0] wireSh = 10'h000;
	logic [8:0] bbSh = 9'h000;
	int miscompares = 0;
	int num_checks = 0;
	dpwcs_link_if link ();
	dpwcs_link_if link2 ();
	dpwcs_master i_dpwcs_master (.clk(clk), .rst(rst), .link(link.master),
		.start(start), .selectAddr(selectAddr), .cmdByte(cmdByte),
		.dataCount(dataCount), .data0(data0), .data1(data1), .busy(busy),
		.done(done), .ackError(ackError));
	dpwcs_device i_dpwcs_device (.clk(clk), .rst(rst), .link(link.device),
		.addressSelectPins(3'h5), .wiper0(wiper0), .wiper1(wiper1),
		.zeroCrossEn(zeroCrossEn));
	// Second device faces a bench driver that injects spikes
	dpwcs_device i_dpwcs_device_b (.clk(clk), .rst(rst),
		.link(link2.device), .addressSelectPins(3'h5), .wiper0(w2a),
		.wiper1(w2b), .zeroCrossEn(zc2));
	dpwcs_link_props i_dpwcs_link_props (.clk(clk), .rst(rst),
		.sclMasterO(link.sclMasterO), .sclMasterOe(link.sclMasterOe),
		.sdaMasterO(link.sdaMasterO), .sdaMasterOe(link.sdaMasterOe),
		.sdaDevO(link.sdaDevO), .sdaDevOe(link.sdaDevOe), .scl(link.scl),
		.sda(link.sda));
	initial begin
		forever #4 clk = ~clk;
	end
	// Wire bits as seen at each clock rise, ack slot included
	always @(posedge link.scl) begin
		wireSh <= {wireSh[8:0], link.sda};
	end
	// ==========================================================
	// Compare and drive tasks
	task automatic cmpV(input string what, input logic [9:0] exp,
		input logic [9:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic cmpB(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	task automatic frame(input logic [2:0] sel, input logic [7:0] cmd,
		input logic [1:0] cnt, input logic [7:0] d0, input logic [7:0] d1);
		@(posedge clk);
		selectAddr <= sel;
		cmdByte <= cmd;
		dataCount <= cnt;
		data0 <= d0;
		data1 <= d1;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		cmpB("busy", 1'b1, busy);
		for (int n = 0; n < 20000 && done !== 1'b1; n++) begin
			@(posedge clk);
		end
		cmpB("done", 1'b1, done);
		#1;
		cmpB("busy low", 1'b0, busy);
		cmpB("bus idle", 1'b1, link.scl & link.sda);
	endtask
	task automatic checkState(input logic [7:0] e0, input logic [7:0] e1,
		input logic ez);
		cmpV("wiper0", 10'(e0), 10'(wiper0));
		cmpV("wiper1", 10'(e1), 10'(wiper1));
		cmpB("zeroCrossEn", ez, zeroCrossEn);
	endtask
	// Spike on both lines while the clock is high, 48 ns wide
	task automatic bbBit(input logic b);
		link2.sdaMasterOe <= ~b;
		repeat (BQ) @(posedge clk);
		link2.sclMasterOe <= 1'b0;
		repeat (BQ) @(posedge clk);
		link2.sclMasterOe <= 1'b1;
		link2.sdaMasterOe <= b;
		repeat (6) @(posedge clk);
		link2.sclMasterOe <= 1'b0;
		link2.sdaMasterOe <= ~b;
		repeat (BQ) @(posedge clk);
		bbSh = {bbSh[7:0], link2.sda};
		link2.sclMasterOe <= 1'b1;
		repeat (BQ) @(posedge clk);
	endtask
	task automatic bbByte(input logic [7:0] v, input logic ack);
		for (int i = 7; i >= 0; i--) bbBit(v[i]);
		bbBit(1'b1);
		cmpB("spiky ack", ack, bbSh[0]);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		checkState(WIPER_RST, WIPER_RST, 1'b1);
	endtask
	task automatic t_pot0();
		frame(3'h5, CMD_POT0, 2'h2, 8'h3c, 8'hc3);
		checkState(8'h3c, 8'hc3, 1'b1);
		cmpB("ackError", 1'b0, ackError);
		cmpV("wire bits", {8'hc3, 2'b00}, wireSh);
		frame(3'h5, CMD_POT0, 2'h1, 8'h81, 8'h00);
		checkState(8'h81, 8'hc3, 1'b1);
	endtask
	task automatic t_pot1();
		frame(3'h5, CMD_POT1, 2'h1, 8'h5a, 8'h00);
		checkState(8'h81, 8'h5a, 1'b1);
		cmpB("ackError", 1'b0, ackError);
	endtask
	task automatic t_both();
		frame(3'h5, CMD_BOTH, 2'h1, 8'h7e, 8'h00);
		checkState(8'h7e, 8'h7e, 1'b1);
	endtask
	task automatic t_zc();
		frame(3'h5, CMD_ZC_OFF, 2'h0, 8'h00, 8'h00);
		checkState(8'h7e, 8'h7e, 1'b0);
		cmpB("ackError", 1'b0, ackError);
		cmpV("wire bits mode", {CMD_ZC_OFF, 2'b00}, wireSh);
		frame(3'h5, CMD_ZC_ON, 2'h0, 8'h00, 8'h00);
		checkState(8'h7e, 8'h7e, 1'b1);
	endtask
	task automatic t_unknown();
		frame(3'h5, 8'hab, 2'h1, 8'h11, 8'h00);
		checkState(8'h7e, 8'h7e, 1'b1);
		cmpB("ackError", 1'b1, ackError);
	endtask
	task automatic t_badAddr();
		frame(3'h2, CMD_BOTH, 2'h1, 8'h22, 8'h00);
		checkState(8'h7e, 8'h7e, 1'b1);
		cmpB("ackError", 1'b1, ackError);
		cmpV("wire bits nack", {8'h54, 2'b10}, wireSh);
	endtask
	task automatic t_glitch();
		@(posedge clk);
		link2.sdaMasterOe <= 1'b1;
		repeat (BQ) @(posedge clk);
		link2.sclMasterOe <= 1'b1;
		// Read direction is refused, then a repeated START
		bbByte({CTRL_TYPE, 3'h5, 1'b1}, 1'b1);
		link2.sclMasterOe <= 1'b0;
		repeat (BQ) @(posedge clk);
		link2.sdaMasterOe <= 1'b1;
		repeat (BQ) @(posedge clk);
		link2.sclMasterOe <= 1'b1;
		bbByte({CTRL_TYPE, 3'h5, DIR_WRITE}, 1'b0);
		bbByte(CMD_POT1, 1'b0);
		bbByte(8'h96, 1'b0);
		link2.sdaMasterOe <= 1'b1;
		repeat (BQ) @(posedge clk);
		link2.sclMasterOe <= 1'b0;
		repeat (BQ) @(posedge clk);
		link2.sdaMasterOe <= 1'b0;
		repeat (BQ) @(posedge clk);
		cmpV("spiky wiper1", 10'h096, 10'(w2b));
		cmpV("spiky wiper0", 10'(WIPER_RST), 10'(w2a));
		cmpB("spiky zc", ZC_RST, zc2);
	endtask
	// ==========================================================
	// Sequence, watchdog and verdict
	task automatic results();
		$display("checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		link2.sclMasterO <= 1'b0;
		link2.sdaMasterO <= 1'b0;
		link2.sclMasterOe <= 1'b0;
		link2.sdaMasterOe <= 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (16) @(posedge clk);
		t_reset();
		t_pot0();
		t_pot1();
		t_both();
		t_zc();
		t_unknown();
		t_badAddr();
		t_glitch();
		results();
	end
	// All frames together take about 76000 cycles
	initial begin
		repeat (98000) @(posedge clk);
		miscompares++;
		results();
	end
endmodule
`default_nettype wire
